// >>> core/panel_consts.svh
// Constants for the front panel setup controller: offsets, field positions,
// reset values and timing counts.
// Assumes a 50 MHz system clock.
`ifndef PANEL_CONSTS_SVH
`define PANEL_CONSTS_SVH
// Clock and key auto-repeat timing (times in ms)
`define CLK_HZ 32'h02faf080
`define REPEAT_DELAY_MS 32'h000001f4
`define REPEAT_PERIOD_MS 32'h00000064
`define REPEAT_DELAY_CYC ((`CLK_HZ / 32'h000003e8) * `REPEAT_DELAY_MS)
`define REPEAT_PERIOD_CYC ((`CLK_HZ / 32'h000003e8) * `REPEAT_PERIOD_MS)
// Carrier in 100 Hz units
`define CAR_INIT 24'h0f4240
`define CAR_MIN 24'h000064
`define CAR_MAX 24'h970fe0
`define CAR_STEP_INIT 24'h0186a0
`define CAR_STEP_MAX 24'h970f7c
// Amplitude in 0.1 dB units, two's complement
`define AMP_INIT 12'hb0a
`define AMP_MAX 12'h0aa
`define AMP_MIN_MAG 12'h4f6
`define AMP_STEP_INIT 11'h064
`define AMP_STEP_MAX 11'h5a0
// AM depth in percent, FM deviation in 0.1 kHz units
`define AM_MAX 7'h63
`define AM_STEP_INIT 7'h01
`define FM_MAX 10'h3de
`define FM_STEP_INIT 10'h00a
`define FM_BAND_EDGE 24'h12d838
`define FM_LIMIT_LOW_BAND 10'h1ef
`define STORE_COUNT 4'ha
// Register byte offsets
`define ADDR_CARRIER 8'h00
`define ADDR_AMPL 8'h04
`define ADDR_MOD 8'h08
`define ADDR_STATUS 8'h0c
`define ADDR_KEY 8'h10
`define ADDR_CAR_STEP 8'h14
// Field positions
`define MOD_AM_LSB 16
`define STAT_FLASH_BIT 4
`define STAT_QUIET_BIT 5
`define STAT_ENTRY_BIT 6
`define STAT_CTR_LSB 8
`define STAT_FUNC_LSB 12
`endif

// >>> core/panel_pkg.sv
// Types for the front panel setup controller.
// Used together with panel_consts.svh.
package panel_pkg;
  typedef enum logic [5:0] {
    KEY_DP = 6'h0a, KEY_MINUS = 6'h0b, KEY_BKSP = 6'h0c, KEY_FREQ = 6'h0d,
    KEY_AMPL = 6'h0e, KEY_AM = 6'h0f, KEY_FM = 6'h10, KEY_CAR_UP = 6'h11,
    KEY_CAR_DN = 6'h12, KEY_AMP_UP = 6'h13, KEY_AMP_DN = 6'h14, KEY_AM_UP = 6'h15,
    KEY_AM_DN = 6'h16, KEY_FM_UP = 6'h17, KEY_FM_DN = 6'h18, KEY_COARSE = 6'h19,
    KEY_FINE = 6'h1a, KEY_LOW_TONE = 6'h1b, KEY_HIGH_TONE = 6'h1c,
    KEY_EXTERNAL = 6'h1d, KEY_SRC_OFF = 6'h1e, KEY_STORE = 6'h1f, KEY_RECALL = 6'h20,
    KEY_DISPLAY = 6'h21, KEY_NEXT_SETUP = 6'h22, KEY_MHZ = 6'h23, KEY_KHZ = 6'h24,
    KEY_HZ = 6'h25, KEY_DBM = 6'h26, KEY_DB = 6'h27, KEY_PCT = 6'h28
  } key_t;
  typedef enum logic [1:0] {
    F_FREQ = 2'b00, F_AMPL = 2'b01, F_AM = 2'b10, F_FM = 2'b11
  } func_t;
  typedef enum logic [1:0] {
    CMD_IDLE = 2'b00, CMD_STORE = 2'b01, CMD_RECALL = 2'b10, CMD_DISPLAY = 2'b11
  } cmd_t;
  typedef enum logic [1:0] {
    VIEW_LIVE = 2'b00, VIEW_STORE = 2'b01, VIEW_CTR = 2'b10
  } view_t;
  typedef struct packed {
    logic [23:0] carrier;
    logic signed [11:0] ampl;
    logic [6:0] am;
    logic [9:0] fm;
    logic tone_low;
    logic tone_high;
    logic external;
    logic show_fm;
  } setup_t;
  typedef struct packed {
    logic [23:0] freq;
    logic [11:0] ampl;
    logic [9:0] modv;
    logic mod_is_fm;
    logic mod_flash;
    logic ampl_is_ctr;
    logic blank;
  } disp_t;
endpackage

// >>> core/front_panel_setup_controller.sv
// Front panel setup controller: key entry, steps, setup stores, quiet mode.
// Keys and switch levels arrive asynchronously on pins; software reaches
// status and a key injection register over AXI4-Lite on clk.
//
// Contract
// [R1] AM/FM key picks 1 kHz if no source
// [R2] AM step from 1 to 99 percent
// [R3] FM step 0.1 to 99 kHz, init 1.0
// [R4] Step once per press, repeat while held
// [R5] AM/FM keys switch the modulation display
// [R6] Flagged deviation: FM keys set band maximum
// [R7] Tone routed out only internal, not external
// [R8] Carrier entries always kept in megahertz; code also takes kHz and Hz terminators and holds 100 Hz units
// [R9] AM needs percent, FM needs kHz terminator
// [R10] Backspace drops last digit or point
// [R11] Minus accepted only for amplitude entries
// [R12] Reset fills all ten stores with defaults
// [R13] Store digit saves settings, not steps
// [R14] Recall digit loads store and output
// [R15] Display digit shows store, output unchanged
// [R16] Next setup key recalls stores in turn
// [R17] Display plus next shows counter digit
// [R18] Step set plus function stores step
// [R19] Reject carrier and amplitude steps over maximum
// [R20] Held step set key shows the step
// [R21] Step set press cancels coarse/fine tuning
// [R22] Quiet standby blanks, mutes; restore on return
// [R23] Coarse multiplies, fine divides tuning step
// [R24] Flash while deviation exceeds band limit
// [R25] Setup counter wraps nine to zero
// [R26] Steps past range leave value unchanged
`include "panel_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module front_panel_setup_controller import panel_pkg::*; #(
  parameter int REPEAT_DELAY_CYC = `REPEAT_DELAY_CYC,
  parameter int REPEAT_PERIOD_CYC = `REPEAT_PERIOD_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic key_down_pin,
  input wire logic [5:0] key_code_pin,
  input wire logic step_value_set_key,
  input wire logic quiet_standby_position,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output setup_t out_setup,
  output logic tone_route_out,
  output logic rf_enable,
  output logic atten_all_in,
  output logic audio_osc_run,
  output disp_t disp
);
  // Pin synchronisers: stage a feeds stage b only
  logic [7:0] pin_a, pin_b;
  logic down_q, rpt_fire, inject_pend, set_q;
  logic [5:0] inject_code;
  logic [31:0] rpt_cnt;
  wire logic down_s = pin_b[0];
  wire logic [5:0] code_s = pin_b[6:1];
  wire logic quiet = pin_b[7];
  logic set_a, set_s;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_a <= 8'h00;
      pin_b <= 8'h00;
      set_a <= 1'b0;
      set_s <= 1'b0;
    end else begin
      pin_a <= {quiet_standby_position, key_code_pin, key_down_pin};
      pin_b <= pin_a;
      set_a <= step_value_set_key;
      set_s <= set_a;
    end
  end

  // Auto-repeat for step keys held down
  wire logic press = down_s & ~down_q;
  wire logic is_step = (code_s >= KEY_CAR_UP) && (code_s <= KEY_FM_DN);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      down_q <= 1'b0;
      rpt_cnt <= 32'h0;
      rpt_fire <= 1'b0;
    end else begin
      down_q <= down_s;
      rpt_fire <= 1'b0;
      if (press) begin
        rpt_cnt <= 32'(REPEAT_DELAY_CYC - 1);
      end else if (down_s && is_step) begin
        if (rpt_cnt == 32'h0) begin
          rpt_fire <= 1'b1; // see [R4]
          rpt_cnt <= 32'(REPEAT_PERIOD_CYC - 1);
        end else begin
          rpt_cnt <= rpt_cnt - 32'h1;
        end
      end
    end
  end

  // Key events; injected keys wait for a free cycle
  wire logic pin_evt = press | rpt_fire;
  wire logic evt = (pin_evt | inject_pend) & ~quiet; // see [R22]
  wire logic [5:0] evt_code = pin_evt ? code_s : inject_code;
  wire logic is_digit = evt_code < 6'h0a;
  wire logic [3:0] digit = evt_code[3:0];

  // AXI4-Lite slave
  wire logic wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = ~s_axi_rvalid;
  logic [31:0] rd_word;
  logic rd_ok;
  setup_t cur;
  func_t func;
  logic dev_flag, entry_active;
  logic [3:0] setup_ctr;
  logic [23:0] tuned_car;
  always_comb begin
    rd_ok = 1'b1;
    rd_word = 32'h0;
    case (s_axi_araddr)
      `ADDR_CARRIER: rd_word = {8'h00, cur.carrier};
      `ADDR_AMPL: rd_word = {{20{cur.ampl[11]}}, cur.ampl};
      `ADDR_MOD: rd_word = {9'h000, cur.am, 6'h00, cur.fm};
      `ADDR_STATUS: begin
        rd_word[3:0] = {cur.show_fm, cur.external, cur.tone_high, cur.tone_low};
        rd_word[`STAT_FLASH_BIT] = dev_flag;
        rd_word[`STAT_QUIET_BIT] = quiet;
        rd_word[`STAT_ENTRY_BIT] = entry_active;
        rd_word[`STAT_CTR_LSB +: 4] = setup_ctr;
        rd_word[`STAT_FUNC_LSB +: 2] = func;
      end
      `ADDR_KEY: rd_word = {26'h0, inject_code};
      `ADDR_CAR_STEP: rd_word = {8'h00, tuned_car};
      default: rd_ok = 1'b0;
    endcase
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0;
    end else begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (s_axi_awaddr == `ADDR_KEY) ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Key injection register; remote keys dropped in standby
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      inject_pend <= 1'b0;
      inject_code <= 6'h00;
    end else begin
      if (evt && !pin_evt) inject_pend <= 1'b0;
      if (quiet) inject_pend <= 1'b0;
      if (wr_go && s_axi_awaddr == `ADDR_KEY && s_axi_wstrb[0] && !quiet) begin
        inject_pend <= 1'b1; // see [R22]
        inject_code <= s_axi_wdata[5:0];
      end
    end
  end

  // Scale an entry by ten to the given power
  function automatic logic [31:0] scale10(input logic [31:0] v, input int sh);
    logic [31:0] r;
    r = v;
    for (int i = 0; i < 8; i++) begin
      if (i < sh) r = 32'(r * 32'd10);
      else if (i < -sh) r = r / 32'd10;
    end
    return r;
  endfunction
  function automatic logic [9:0] fm_limit(input logic [23:0] car);
    return (car < `FM_BAND_EDGE) ? `FM_LIMIT_LOW_BAND : `FM_MAX;
  endfunction

  // Setup stores
  setup_t stores [`STORE_COUNT];
  setup_t init_setup;
  logic store_we;
  logic [3:0] store_idx;
  assign init_setup = '{carrier: `CAR_INIT, ampl: `AMP_INIT, am: 7'h00, fm: 10'h000,
                        tone_low: 1'b0, tone_high: 1'b0, external: 1'b0, show_fm: 1'b0};
  always_ff @(posedge clk) begin
    for (int i = 0; i < int'(`STORE_COUNT); i++) begin
      if (sys_rst) stores[i] <= init_setup; // see [R12]
      else if (store_we && store_idx == 4'(i)) stores[i] <= cur; // see [R13]
    end
  end

  // Entry and panel state
  logic [6:0] step_am;
  logic [9:0] step_fm, lim;
  logic [10:0] step_amp;
  logic [23:0] step_car;
  logic [31:0] entry_val, scaled;
  logic [2:0] entry_frac;
  logic entry_dp, entry_neg, step_mode;
  cmd_t cmd;
  view_t view;
  logic [3:0] view_idx;
  int term_exp;
  logic term_ok;
  assign lim = fm_limit(cur.carrier);
  always_comb begin
    term_ok = 1'b0;
    term_exp = 0;
    case (evt_code)
      KEY_MHZ: begin term_ok = (func == F_FREQ); term_exp = 4; end // see [R8]
      KEY_KHZ: begin term_ok = (func == F_FREQ) || (func == F_FM); term_exp = 1; end
      KEY_HZ: begin term_ok = (func == F_FREQ); term_exp = -2; end
      KEY_DBM, KEY_DB: begin term_ok = (func == F_AMPL); term_exp = 1; end
      KEY_PCT: begin term_ok = (func == F_AM); term_exp = 0; end // see [R9]
      default: ;
    endcase
    scaled = scale10(entry_val, term_exp - int'(entry_frac));
  end
  assign store_idx = digit;
  assign store_we = evt && is_digit && cmd == CMD_STORE;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur <= init_setup;
      func <= F_FREQ;
      step_car <= `CAR_STEP_INIT;
      tuned_car <= `CAR_STEP_INIT;
      step_amp <= `AMP_STEP_INIT;
      step_am <= `AM_STEP_INIT; // see [R2]
      step_fm <= `FM_STEP_INIT; // see [R3]
      {entry_active, entry_dp, entry_neg, step_mode} <= 4'h0;
      entry_val <= 32'h0;
      entry_frac <= 3'h0;
      cmd <= CMD_IDLE;
      view <= VIEW_LIVE;
      view_idx <= 4'h0;
      setup_ctr <= 4'h0;
      set_q <= 1'b0;
    end else begin
      set_q <= set_s;
      if (set_s && !set_q) tuned_car <= step_car; // see [R21]
      if (evt) begin
        view <= VIEW_LIVE;
        cmd <= CMD_IDLE;
        if (is_digit && cmd != CMD_IDLE) begin
          if (cmd == CMD_RECALL) cur <= stores[digit]; // see [R14]
          if (cmd == CMD_DISPLAY) begin
            view <= VIEW_STORE; // see [R15]
            view_idx <= digit;
          end
        end else if (is_digit) begin
          entry_active <= 1'b1;
          if (!entry_active) begin
            entry_val <= {28'h0, digit};
            {entry_frac, entry_dp, entry_neg} <= 5'h00;
          end else if (entry_val < 32'h00989680 && entry_frac < 3'h7) begin
            entry_val <= 32'(entry_val * 32'd10 + {28'h0, digit});
            entry_frac <= entry_frac + {2'b00, entry_dp};
          end
        end else begin
          case (key_t'(evt_code))
            KEY_DP: if (!entry_dp) begin
              entry_dp <= 1'b1;
              if (!entry_active) {entry_active, entry_val, entry_frac, entry_neg} <= {1'b1, 36'h0};
            end
            KEY_MINUS: if (func == F_AMPL && !step_mode) begin
              entry_neg <= ~entry_neg; // see [R11]
              if (!entry_active) {entry_active, entry_val, entry_frac, entry_dp} <= {1'b1, 36'h0};
            end
            KEY_BKSP: if (entry_active) begin
              if (entry_dp && entry_frac == 3'h0) entry_dp <= 1'b0; // see [R10]
              else begin
                entry_val <= entry_val / 32'd10;
                if (entry_frac != 3'h0) entry_frac <= entry_frac - 3'h1;
              end
            end
            KEY_FREQ, KEY_AMPL, KEY_AM, KEY_FM: begin
              func <= func_t'(evt_code[1:0] - 2'b01);
              step_mode <= set_s; // see [R18]
              entry_active <= 1'b0;
              if (evt_code == KEY_AM || evt_code == KEY_FM) begin
                cur.show_fm <= (evt_code == KEY_FM); // see [R5]
                if (!cur.tone_low && !cur.tone_high && !cur.external)
                  cur.tone_high <= 1'b1; // see [R1]
                if (evt_code == KEY_FM && dev_flag) cur.fm <= lim; // see [R6]
              end
            end
            KEY_CAR_UP: if (25'(cur.carrier) + 25'(tuned_car) <= 25'(`CAR_MAX))
              cur.carrier <= cur.carrier + tuned_car; // see [R26]
            KEY_CAR_DN: if (cur.carrier >= tuned_car + `CAR_MIN)
              cur.carrier <= cur.carrier - tuned_car; // see [R4]
            KEY_AMP_UP: if ($signed({cur.ampl[11], cur.ampl}) + $signed({2'b00, step_amp})
                            <= $signed({1'b0, `AMP_MAX}))
              cur.ampl <= 12'(cur.ampl + {1'b0, step_amp});
            KEY_AMP_DN: if ($signed({cur.ampl[11], cur.ampl}) - $signed({2'b00, step_amp})
                            >= -$signed({1'b0, `AMP_MIN_MAG}))
              cur.ampl <= 12'(cur.ampl - {1'b0, step_amp});
            KEY_AM_UP: if (8'(cur.am) + 8'(step_am) <= 8'(`AM_MAX)) cur.am <= cur.am + step_am;
            KEY_AM_DN: if (cur.am >= step_am) cur.am <= cur.am - step_am;
            KEY_FM_UP: if (dev_flag) cur.fm <= lim; // see [R6]
              else if (11'(cur.fm) + 11'(step_fm) <= 11'(lim)) cur.fm <= cur.fm + step_fm;
            KEY_FM_DN: if (dev_flag) cur.fm <= lim;
              else if (cur.fm >= step_fm) cur.fm <= cur.fm - step_fm;
            KEY_COARSE: if (28'(tuned_car * 28'd10) <= {4'h0, `CAR_STEP_MAX})
              tuned_car <= 24'(tuned_car * 24'd10); // see [R23]
            KEY_FINE: if (tuned_car >= 24'd10) tuned_car <= tuned_car / 24'd10;
            KEY_LOW_TONE: {cur.tone_low, cur.tone_high} <= 2'b10;
            KEY_HIGH_TONE: {cur.tone_low, cur.tone_high} <= 2'b01;
            KEY_EXTERNAL: cur.external <= 1'b1;
            KEY_SRC_OFF: {cur.tone_low, cur.tone_high, cur.external} <= 3'b000;
            KEY_STORE: cmd <= CMD_STORE;
            KEY_RECALL: cmd <= CMD_RECALL;
            KEY_DISPLAY: cmd <= CMD_DISPLAY;
            KEY_NEXT_SETUP: if (cmd == CMD_DISPLAY) view <= VIEW_CTR; // see [R17]
              else begin
                cur <= stores[setup_ctr]; // see [R16]
                setup_ctr <= (setup_ctr == 4'h9) ? 4'h0 : setup_ctr + 4'h1; // see [R25]
              end
            default: if (term_ok && entry_active) begin
              entry_active <= 1'b0;
              if (!step_mode) case (func)
                F_FREQ: if (scaled >= 32'(`CAR_MIN) && scaled <= 32'(`CAR_MAX))
                  cur.carrier <= scaled[23:0]; // see [R8]
                F_AMPL: if (scaled <= (entry_neg ? 32'(`AMP_MIN_MAG) : 32'(`AMP_MAX)))
                  cur.ampl <= entry_neg ? 12'(-scaled[11:0]) : scaled[11:0];
                F_AM: if (scaled <= 32'(`AM_MAX)) cur.am <= scaled[6:0]; // see [R9]
                default: if (scaled <= 32'(lim)) cur.fm <= scaled[9:0];
              endcase
              else case (func)
                F_FREQ: if (scaled >= 32'h1 && scaled <= 32'(`CAR_STEP_MAX)) begin
                  step_car <= scaled[23:0]; // see [R19]
                  tuned_car <= scaled[23:0];
                end
                F_AMPL: if (scaled >= 32'h1 && scaled <= 32'(`AMP_STEP_MAX))
                  step_amp <= scaled[10:0]; // see [R19]
                F_AM: if (scaled >= 32'h1 && scaled <= 32'(`AM_MAX))
                  step_am <= scaled[6:0]; // see [R2]
                default: if (scaled >= 32'h1 && scaled <= 32'(`FM_MAX))
                  step_fm <= scaled[9:0]; // see [R3]
              endcase
            end
          endcase
        end
      end
    end
  end

  // Deviation over band limit, re-evaluated after every carrier change
  always_ff @(posedge clk) begin
    if (sys_rst) dev_flag <= 1'b0;
    else dev_flag <= cur.fm > lim; // see [R24]
  end

  // Hardware controls and displays
  setup_t shown;
  assign shown = (view == VIEW_STORE) ? stores[view_idx] : cur;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_setup <= init_setup;
      {tone_route_out, rf_enable, atten_all_in, audio_osc_run} <= 4'b0010;
      disp <= '0;
    end else begin
      out_setup <= cur;
      tone_route_out <= ~quiet & (cur.tone_low | cur.tone_high) & ~cur.external; // see [R7]
      rf_enable <= ~quiet; // see [R22]
      atten_all_in <= quiet;
      audio_osc_run <= ~quiet & (cur.tone_low | cur.tone_high);
      disp.blank <= quiet;
      disp.mod_flash <= dev_flag;
      disp.freq <= (set_s && func == F_FREQ) ? step_car : shown.carrier; // see [R20]
      disp.ampl <= (view == VIEW_CTR) ? {8'h00, setup_ctr} : // see [R17]
                   (set_s && func == F_AMPL) ? {1'b0, step_amp} : shown.ampl;
      disp.ampl_is_ctr <= (view == VIEW_CTR);
      disp.mod_is_fm <= shown.show_fm;
      if (set_s && func == F_AM) disp.modv <= {3'b000, step_am};
      else if (set_s && func == F_FM) disp.modv <= step_fm;
      else disp.modv <= shown.show_fm ? shown.fm : {3'b000, shown.am};
    end
  end

  // Checks
  a_default_tone: assert property (@(posedge clk) disable iff (sys_rst) // see [R1]
    evt && cmd == CMD_IDLE && (evt_code == KEY_AM || evt_code == KEY_FM) &&
    !cur.tone_low && !cur.tone_high && !cur.external |=> cur.tone_high)
    else $error("default tone not selected");
  a_am_step_range: assert property (@(posedge clk) disable iff (sys_rst) // see [R2]
    step_am >= 7'h01 && step_am <= `AM_MAX) else $error("AM step out of range");
  a_fm_step_range: assert property (@(posedge clk) disable iff (sys_rst) // see [R3]
    step_fm >= 10'h001 && step_fm <= `FM_MAX) else $error("FM step out of range");
  a_am_step_once: assert property (@(posedge clk) disable iff (sys_rst) // see [R4]
    evt && evt_code == KEY_AM_UP && cmd == CMD_IDLE |=>
    cur.am == (8'($past(cur.am)) + 8'($past(step_am)) <= 8'(`AM_MAX) ? // see [R26]
               $past(cur.am) + $past(step_am) : $past(cur.am)))
    else $error("AM step wrong");
  a_mod_view_fm: assert property (@(posedge clk) disable iff (sys_rst) // see [R5]
    evt && cmd == CMD_IDLE && evt_code == KEY_FM |=> cur.show_fm ##2 disp.mod_is_fm)
    else $error("FM view not selected");
  a_dev_fix: assert property (@(posedge clk) disable iff (sys_rst) // see [R6]
    evt && cmd == CMD_IDLE && dev_flag && evt_code == KEY_FM_UP |=> cur.fm == $past(lim))
    else $error("deviation not set to band maximum");
  a_tone_route: assert property (@(posedge clk) disable iff (sys_rst) // see [R7]
    tone_route_out |-> $past(cur.external) == 1'b0 && $past(cur.tone_low | cur.tone_high))
    else $error("tone routed wrongly");
  a_quiet_out: assert property (@(posedge clk) disable iff (sys_rst) // see [R22]
    quiet |=> !rf_enable && atten_all_in && disp.blank && !audio_osc_run)
    else $error("standby outputs not quiet");
  a_ctr_wrap: assert property (@(posedge clk) disable iff (sys_rst) // see [R25]
    evt && evt_code == KEY_NEXT_SETUP && cmd != CMD_DISPLAY && setup_ctr == 4'h9
    |=> setup_ctr == 4'h0) else $error("counter did not wrap");
  a_reset_stores: assert property (@(posedge clk) // see [R12]
    sys_rst |=> stores[0] == init_setup && stores[9] == init_setup)
    else $error("stores not initialised");
  c_recall: cover property (@(posedge clk) evt && is_digit && cmd == CMD_RECALL);
  c_next_setup: cover property (@(posedge clk) evt && evt_code == KEY_NEXT_SETUP);
  c_repeat: cover property (@(posedge clk) rpt_fire);
  c_flash: cover property (@(posedge clk) dev_flag ##1 !dev_flag);
endmodule // front_panel_setup_controller
`default_nettype wire

// >>> bench/keypad_model.sv
// Keypad model: presses one panel key at a time on the key pins.
// Assumes the bench clock; the code lines are only valid while a key is down.
`timescale 1ns/1ps
`default_nettype none
module keypad_model import panel_pkg::*; (
  input wire logic clk,
  output logic key_down_pin,
  output logic [5:0] key_code_pin
);
  initial begin
    key_down_pin = 1'b0;
    key_code_pin = 6'h00;
  end
  // Holds a key for six edges, then keeps it released for six
  task automatic press(input logic [5:0] code);
    @(posedge clk);
    key_code_pin <= code;
    key_down_pin <= 1'b1;
    repeat (6) @(posedge clk);
    key_down_pin <= 1'b0;
    key_code_pin <= ~code; // A released keypad no longer shows the code
    repeat (6) @(posedge clk);
  endtask
endmodule // keypad_model
`default_nettype wire

// >>> bench/tb_top.sv
// Testbench: key sequences through the keypad model plus register reads.
// Assumes the design package, constants header and a 50 MHz clock.
`include "panel_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top import panel_pkg::*;;
  logic clk = 1'b0, sys_rst = 1'b1, quiet = 1'b0, sset = 1'b0, kd;
  logic [5:0] kc;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, tone, rf, atten, osc;
  logic [1:0] bresp, rresp, rs;
  setup_t os;
  disp_t disp;
  int err_count = 0, compares = 0;
  always #10 clk = ~clk;
  keypad_model i_keypad_model (.clk(clk), .key_down_pin(kd), .key_code_pin(kc));
  front_panel_setup_controller #(.REPEAT_DELAY_CYC(8), .REPEAT_PERIOD_CYC(4))
    i_front_panel_setup_controller (.clk(clk), .sys_rst(sys_rst), .key_down_pin(kd),
    .key_code_pin(kc), .step_value_set_key(sset), .quiet_standby_position(quiet),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .out_setup(os), .tone_route_out(tone), .rf_enable(rf), .atten_all_in(atten),
    .audio_osc_run(osc), .disp(disp));
  // Compares one value and reports a mismatch
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Presses a key sequence
  task automatic keys(input logic [5:0] s[$]);
    foreach (s[i]) i_keypad_model.press(s[i]);
  endtask
  // Register write: address and data offered together
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(posedge clk);
    while (!(awready && wready)) @(posedge clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(posedge clk);
    while (!bvalid) @(posedge clk);
    r = bresp;
    bready <= 1'b0;
  endtask
  // Register read
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge clk);
    while (!arready) @(posedge clk);
    arvalid <= 1'b0;
    @(posedge clk);
    while (!rvalid) @(posedge clk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Prints the counts and the verdict
  task automatic close_out();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    #400000;
    err_count++;
    close_out();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk("carrier", 32'h0f4240, {8'h00, os.carrier});
    chk("ampl", 32'hb0a, {20'h0, os.ampl});
    keys('{KEY_AM, KEY_AM_DN});
    chk("tone_high", 32'h1, {31'h0, os.tone_high});
    chk("route", 32'h1, {31'h0, tone});
    chk("am floor", 32'h0, {25'h0, os.am});
    keys('{KEY_AM_UP});
    chk("am step", 32'h1, {25'h0, os.am});
    keys('{KEY_FM});
    chk("show fm", 32'h1, {31'h0, disp.mod_is_fm});
    keys('{KEY_AM, KEY_EXTERNAL});
    chk("show am", 32'h0, {31'h0, disp.mod_is_fm});
    chk("route ext", 32'h0, {31'h0, tone});
    keys('{KEY_FREQ, 6'h05, 6'h00, 6'h00, KEY_KHZ});
    axr(`ADDR_CARRIER, rd, rs);
    chk("khz entry", 32'h1388, rd);
    keys('{KEY_STORE, 6'h03, KEY_FREQ, 6'h02, KEY_MHZ});
    chk("mhz entry", 32'h4e20, {8'h00, os.carrier});
    keys('{KEY_DISPLAY, 6'h03});
    chk("display", 32'h4e20, {8'h00, os.carrier});
    chk("display freq", 32'h1388, {8'h00, disp.freq});
    keys('{KEY_RECALL, 6'h03});
    chk("recall", 32'h1388, {8'h00, os.carrier});
    quiet <= 1'b1;
    repeat (8) @(posedge clk);
    chk("quiet", 32'h5, {28'h0, rf, atten, osc, disp.blank});
    axw(`ADDR_KEY, {26'h0, KEY_NEXT_SETUP}, rs);
    chk("quiet bresp", 32'h0, {30'h0, rs});
    quiet <= 1'b0;
    repeat (8) @(posedge clk);
    chk("on", 32'h01001388, {7'h00, rf, os.carrier});
    keys('{KEY_DISPLAY, KEY_NEXT_SETUP});
    chk("ctr view", 32'h1000, {19'h0, disp.ampl_is_ctr, disp.ampl});
    axw(`ADDR_KEY, {26'h0, KEY_NEXT_SETUP}, rs);
    repeat (3) @(posedge clk);
    chk("next setup", 32'h0f4240, {8'h00, os.carrier});
    axr(`ADDR_STATUS, rd, rs);
    chk("counter", 32'h1, {28'h0, rd[11:8]});
    sset <= 1'b1;
    repeat (4) @(posedge clk);
    keys('{KEY_AM, 6'h05, KEY_PCT});
    chk("step shown", 32'h5, {22'h0, disp.modv});
    sset <= 1'b0;
    keys('{KEY_AM_UP});
    chk("am by step", 32'h5, {25'h0, os.am});
    axr(8'h40, rd, rs);
    chk("rresp", 32'h2, {30'h0, rs});
    axw(8'h40, 32'h0, rs);
    chk("bresp", 32'h2, {30'h0, rs});
    close_out();
  end
endmodule // tb_top
`default_nettype wire
